// ### inc/tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
	logic clear;
	logic tick;
	modport src(input clear, output tick);
	modport dst(output clear, input tick);
endinterface
`default_nettype wire

// ### inc/wdt_pkg.sv
package wdt_pkg;
	// i/o port address of the watchdog control port
	localparam logic [15:0] WDT_PORT_ADDR = 16'h0443;
	localparam logic [7:0] WDT_CMD_REFRESH = 8'h01;
	localparam logic [7:0] WDT_CMD_DISABLE = 8'h00;
	// timing
	localparam int CLK_HZ = 100_000_000;
	localparam int TIMEOUT_MS = 1600;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam int TIMEOUT_TICKS = TIMEOUT_MS * 1000 / TICK_US;
	localparam int RESET_PULSE_CYCLES = 16;
	localparam logic RESET_ENABLE = 1'b1;
	localparam logic [7:0] RESET_READ_DATA = 8'h00;
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_RUN = 2'b01,
		ST_FIRE = 2'b10
	} wdt_state_t;
endpackage

// ### src/io_port_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module io_port_watchdog
	import wdt_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES,
	parameter int TIMEOUT_LEN = TIMEOUT_TICKS
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// i/o port access
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	// status and cpu reset
	output logic wdt_enabled,
	output logic cpu_reset
);
	logic rst_s1_q;
	logic rst_n_q;
	wdt_state_t state_q;
	wdt_state_t state_d;
	logic [31:0] ticks_q;
	logic [31:0] ticks_d;
	logic [7:0] fire_q;
	logic [7:0] fire_d;
	logic [7:0] rdata_q;
	tick_if tk();

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	wdt_prescaler #(.TICK_LEN(TICK_LEN)) u_pre (
		.clk_sys(clk_sys),
		.rst_n(rst_n_q),
		.t(tk)
	);

	wire logic hit = (io_addr == WDT_PORT_ADDR);
	wire logic wr_one = hit && io_wr && (io_wdata == WDT_CMD_REFRESH);
	wire logic wr_zero = hit && io_wr && (io_wdata == WDT_CMD_DISABLE);
	wire logic rd_hit = hit && io_rd;
	wire logic expired = (ticks_q == 32'(TIMEOUT_LEN - 1)) && tk.tick;

	assign tk.clear = wr_one || rd_hit || (state_q != ST_RUN);

	always_comb begin
		state_d = state_q;
		ticks_d = ticks_q;
		fire_d = fire_q;
		case (state_q)
			ST_OFF: begin
				if (wr_one || rd_hit) begin
					state_d = ST_RUN;
					ticks_d = 32'h0000_0000;
				end
			end
			ST_RUN: begin
				if (wr_zero) begin
					state_d = ST_OFF;
				// refresh restarts interval
				// a read restarts it too, matching the cleared prescaler
				end else if (wr_one || rd_hit) begin
					ticks_d = 32'h0000_0000;
				end else if (expired) begin
					state_d = ST_FIRE;
					fire_d = 8'(RESET_PULSE_CYCLES - 1);
				end else if (tk.tick) begin
					ticks_d = ticks_q + 32'h0000_0001;
				end
			end
			ST_FIRE: begin
				// reset pulse runs out, then the watchdog rearms as after reset
				if (fire_q == 8'h00) begin
					state_d = ST_RUN;
					ticks_d = 32'h0000_0000;
				end else begin
					fire_d = fire_q - 8'h01;
				end
			end
			default: begin
				state_d = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= ST_RUN;
			ticks_q <= 32'h0000_0000;
			fire_q <= 8'h00;
			rdata_q <= RESET_READ_DATA;
		end else begin
			state_q <= state_d;
			ticks_q <= ticks_d;
			fire_q <= fire_d;
			if (rd_hit) begin
				rdata_q <= {7'h00, state_q != ST_OFF};
			end
		end
	end

	assign io_rdata = rdata_q;
	assign wdt_enabled = (state_q != ST_OFF);
	assign cpu_reset = (state_q == ST_FIRE);
endmodule
`default_nettype wire

// ### src/wdt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module wdt_prescaler
	import wdt_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	tick_if.src t
);
	logic [31:0] cnt_q;
	wire logic at_end = (cnt_q == 32'(TICK_LEN - 1));

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 32'h0000_0000;
		end else if (t.clear || at_end) begin
			cnt_q <= 32'h0000_0000;
		end else begin
			cnt_q <= cnt_q + 32'h0000_0001;
		end
	end

	// restart on refresh so the first tick is a full period away
	assign t.tick = at_end && !t.clear;
endmodule
`default_nettype wire

// ### tb/io_port_watchdog_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module io_port_watchdog_assertions(
	input wire logic clk_sys, resetn, io_wr, io_rd, wdt_enabled, cpu_reset,
	input wire logic [15:0] io_addr,
	input wire logic [7:0] io_wdata, io_rdata
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// accesses during the reset pulse are ignored
	wire hit = io_addr == 16'h0443 && !cpu_reset;
	boot_enabled_a: assert property (disable iff (1'b0) $rose(resetn) |-> wdt_enabled && !cpu_reset) else $error("off in reset");
	refresh_on_a: assert property (hit && io_wr && io_wdata == 8'h01 |=> wdt_enabled ##0 (!cpu_reset) [*8])
		else $error("refresh failed");
	read_on_a: assert property (hit && io_rd |=> wdt_enabled) else $error("read no enable");
	write_off_a: assert property (hit && io_wr && io_wdata == 8'h00 |=> !wdt_enabled) else $error("not off");
	off_quiet_a: assert property (!wdt_enabled && !cpu_reset |=> !cpu_reset) else $error("fired off");
	fire_cause_a: assert property ($rose(cpu_reset) |-> $past(wdt_enabled)) else $error("bad fire");
	pulse_len_a: assert property ($rose(cpu_reset) |-> cpu_reset [*8]) else $error("short pulse");
	cover property (hit && io_rd);
	cover property ($rose(cpu_reset));
	cover property (hit && io_wr && io_wdata == 8'h00);
endmodule
bind io_port_watchdog io_port_watchdog_assertions u_io_port_watchdog_assertions(.*);
`default_nettype wire

// ### tb/io_port_watchdog_bench.sv
`timescale 1ns/1ps
`default_nettype none
module io_port_watchdog_bench;
	import wdt_pkg::*;
	`define CHK(s, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("Error %s exp %0h got %0h", s, e, g); end end
	logic clk_sys = 0, resetn = 0, io_wr = 0, io_rd = 0, cpu_reset, wdt_enabled;
	logic [15:0] io_addr = WDT_PORT_ADDR;
	logic [7:0] io_wdata = 8'h00, io_rdata;
	int num_errors = 0, checks = 0, n;
	always #5 clk_sys = ~clk_sys;
	// 4 x 5 = 20 cycle nominal timeout
	io_port_watchdog #(.TICK_LEN(4), .TIMEOUT_LEN(5)) u_io_port_watchdog(.*);
	task test_done;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task acc(input logic w, input logic [7:0] d);
		@(negedge clk_sys);
		io_wr = w;
		io_rd = !w;
		io_wdata = d;
		@(negedge clk_sys);
		io_wr = 0;
		io_rd = 0;
	endtask
	// band is +-30 percent plus the reset synchroniser
	task fire_in_band;
		n = 0;
		while (!cpu_reset && n < 40) begin
			@(negedge clk_sys);
			n++;
		end
		`CHK("timeout", 1'b1, n >= 14 && n <= 28)
		if (n == 40) test_done;
		repeat (20) @(negedge clk_sys);
	endtask
	task t_boot;
		fire_in_band;
	endtask
	task t_off;
		acc(1'b1, WDT_CMD_DISABLE);
		`CHK("enabled", 1'b0, wdt_enabled)
		repeat (40) @(negedge clk_sys);
		`CHK("cpu_reset", 1'b0, cpu_reset)
		acc(1'b0, 8'h00);
		`CHK("rdata", 1'b0, io_rdata[0])
		`CHK("enabled", 1'b1, wdt_enabled)
	endtask
	task t_refresh;
		repeat (5) begin
			acc(1'b1, WDT_CMD_REFRESH);
			repeat (10) @(negedge clk_sys);
		end
		`CHK("cpu_reset", 1'b0, cpu_reset)
		// last refresh starts the full interval measured below
		acc(1'b1, WDT_CMD_REFRESH);
		fire_in_band;
	endtask
	initial begin
		repeat (2) @(negedge clk_sys);
		resetn = 1;
		t_boot;
		t_off;
		t_refresh;
		test_done;
	end
endmodule
`default_nettype wire
